// >>> verilog/dual_role_pkg.sv
// Notes on behaviour
// - Local connect bit 4 drives the DP pull-up; software holds it 5-10 ms.
// - VBUS charge bit 1 charges VBUS; software holds it 10-20 ms after pulsing.
// - VBUS discharge bit 2 enables the discharge path, optionally about 30 ms.
// - Request detect uses VBUS pulsing (bit 9 = 0) or data lines (1), if bit 10.
// - Detect-enable bit 10 low suppresses every session request event.
// - Data-line detection accepts pulsing on either DP or DM.
// - One loadable timer in 10 us units, expiry reported as an event.
// - Status changes and timer expiry set flags; each enable bit gates its flag's interrupt, and the wake for request, id and B session-valid.
// - Status reports id, session valid, session end, overcurrent, line state.
// - Control drives VBUS source, charge, discharge, DP pull-up, pull-downs, detection.
// - Interrupt line needs event enables, summary enable bit 9 and pin gate bit 0.
// - Config bits 1 and 2 pick trigger mode and polarity; reset level, active low.
// - Power saving outside a session suspends controllers and stops PLL, oscillator.
// - Request, id change or B session-valid wake the part if enabled.
// - Any register access wakes the part from power saving, except a power-save write outside a session.
package dual_role_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte addresses
	localparam logic [7:0] CONTROL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] EVENT_FLAGS_ADDR = 8'h08;
	localparam logic [7:0] EVENT_MASK_ADDR = 8'h0C;
	localparam logic [7:0] TIMER_ADDR = 8'h10;
	localparam logic [7:0] HOST_FLAGS_ADDR = 8'h14;
	localparam logic [7:0] HOST_MASK_ADDR = 8'h18;
	localparam logic [7:0] HW_CONFIG_ADDR = 8'h1C;
	localparam logic [7:0] POWER_ADDR = 8'h20;
	// control fields
	localparam int CTL_VBUS_DRIVE = 0;
	localparam int CTL_VBUS_CHARGE = 1;
	localparam int CTL_VBUS_DISCHARGE = 2;
	localparam int CTL_DP_PULLDOWN = 3;
	localparam int CTL_LOCAL_CONNECT = 4;
	localparam int CTL_DM_PULLDOWN = 5;
	localparam int CTL_REQ_SELECT = 9;
	localparam int CTL_DETECT_EN = 10;
	localparam int CTL_W = 11;
	localparam logic [10:0] CTL_RESET = 11'h000;
	localparam logic [10:0] CTL_WRITABLE = 11'h63F;
	// status fields (bits 0..7 are synchronised pins)
	localparam int ST_ID = 0;
	localparam int ST_A_VBUS_VLD = 1;
	localparam int ST_B_SESS_END = 2;
	localparam int ST_A_SESS_VLD = 3;
	localparam int ST_B_SESS_VLD = 4;
	localparam int ST_OVERCURRENT = 5;
	localparam int ST_DP = 6;
	localparam int ST_DM = 7;
	localparam int ST_SE0 = 8;
	localparam int ST_SE0_TWO_MILLI = 9;
	localparam int PIN_W = 8;
	localparam int ST_W = 10;
	// event flag fields; bits 0..5 flag changes of status bits 0..5
	localparam int EV_LINE_CHANGE = 6;
	localparam int EV_SESSION_REQ = 7;
	localparam int EV_TIMER = 8;
	localparam int EV_W = 9;
	localparam logic [8:0] EV_MASK_RESET = 9'h000;
	// host flag / mask and config fields
	localparam int HOST_SUMMARY = 9;
	localparam int CFG_PIN_GATE = 0;
	localparam int CFG_EDGE_MODE = 1;
	localparam int CFG_ACTIVE_HIGH = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam int PWR_SAVE = 0;
	localparam int PWR_AWAKE = 1;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TIMER_TICK_NS = 10000;
	localparam int TIMER_TICK_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;
	localparam int SE0_HOLD_NS = 2000000;
	localparam int SE0_HOLD_CYCLES = SE0_HOLD_NS / CLK_PERIOD_NS;
	localparam int IRQ_PULSE_NS = 160;
	localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 16;
endpackage : dual_role_pkg

// >>> verilog/negotiation_timer.sv
`timescale 1ns/1ps
module negotiation_timer
	import dual_role_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// load port
	input wire logic load,
	input wire logic [TIMER_W-1:0] load_value,
	// state
	output logic [TIMER_W-1:0] count,
	output logic expired
);
	logic [TIMER_W-1:0] count_reg;
	logic [TIMER_W-1:0] count_next;
	logic [8:0] div_reg;
	logic [8:0] div_next;
	logic expired_reg;
	wire running = count_reg != '0;
	wire tick = running && (div_reg == 9'(TIMER_TICK_CYCLES - 1));

	// the divider restarts on every load so the first tick is a full 10 us away
	assign div_next = (load || !running || tick) ? 9'h000 : div_reg + 9'h001;
	assign count_next = load ? load_value : (tick ? count_reg - 16'h0001 : count_reg);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= '0;
			div_reg <= '0;
			expired_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			div_reg <= div_next;
			expired_reg <= tick && !load && (count_reg == 16'h0001);
		end
	end

	assign count = count_reg;
	assign expired = expired_reg;
endmodule : negotiation_timer

// >>> verilog/dual_role_session.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module dual_role_session
	import dual_role_pkg::*;
#(
	parameter int SE0_TWO_MS_CYCLES = SE0_HOLD_CYCLES
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [DATA_W-1:0] rd_data,
	// port sense pins, asynchronous
	input wire logic id_pin,
	input wire logic a_vbus_vld_pin,
	input wire logic b_sess_end_pin,
	input wire logic a_sess_vld_pin,
	input wire logic b_sess_vld_pin,
	input wire logic overcurrent_pin,
	input wire logic dp_pin,
	input wire logic dm_pin,
	// port analog controls
	output logic vbus_drive,
	output logic vbus_charge,
	output logic vbus_discharge,
	output logic dp_pullup_en,
	output logic dp_pulldown_en,
	output logic dm_pulldown_en,
	// shared interrupt line
	output logic irq_line_one,
	// power control
	output logic pll_osc_enable,
	output logic controllers_suspend
);
	// ---------------- pin synchronisers ----------------
	logic [PIN_W-1:0] pin_meta_reg;
	logic [PIN_W-1:0] pin_sync_reg;
	logic [PIN_W-1:0] pin_prev_reg;
	logic [1:0] prime_reg;
	wire [PIN_W-1:0] pin_raw = {dm_pin, dp_pin, overcurrent_pin, b_sess_vld_pin,
		a_sess_vld_pin, b_sess_end_pin, a_vbus_vld_pin, id_pin};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			pin_prev_reg <= '0;
			prime_reg <= 2'h0;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
			if (prime_reg != 2'h3) begin
				prime_reg <= prime_reg + 2'h1;
			end
		end
	end

	// edges are ignored until the chain has refilled after reset, so a pin
	// that idles high does not report a false change
	wire pins_primed = prime_reg == 2'h3;
	wire [PIN_W-1:0] pin_rise = pins_primed ? (pin_sync_reg & ~pin_prev_reg) : '0;
	wire [PIN_W-1:0] pin_change = pins_primed ? (pin_sync_reg ^ pin_prev_reg) : '0;

	// ---------------- register decode ----------------
	wire sel_control = addr == CONTROL_ADDR;
	wire sel_status = addr == STATUS_ADDR;
	wire sel_flags = addr == EVENT_FLAGS_ADDR;
	wire sel_mask = addr == EVENT_MASK_ADDR;
	wire sel_timer = addr == TIMER_ADDR;
	wire sel_host_flags = addr == HOST_FLAGS_ADDR;
	wire sel_host_mask = addr == HOST_MASK_ADDR;
	wire sel_config = addr == HW_CONFIG_ADDR;
	wire sel_power = addr == POWER_ADDR;

	wire wr_control = wr_strobe && sel_control;
	wire wr_flags = wr_strobe && sel_flags;
	wire wr_mask = wr_strobe && sel_mask;
	wire wr_timer = wr_strobe && sel_timer;
	wire wr_host_mask = wr_strobe && sel_host_mask;
	wire wr_config = wr_strobe && sel_config;
	wire wr_power = wr_strobe && sel_power;

	// ---------------- control register ----------------
	logic [CTL_W-1:0] control_reg;
	logic [CTL_W-1:0] control_next;

	assign control_next = wr_control ? (wr_data[CTL_W-1:0] & CTL_WRITABLE) : control_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control_reg <= CTL_RESET;
		end else begin
			control_reg <= control_next;
		end
	end

	// pad outputs follow the register bits; software owns the pulse timing
	assign vbus_drive = control_reg[CTL_VBUS_DRIVE];
	assign vbus_charge = control_reg[CTL_VBUS_CHARGE];
	assign vbus_discharge = control_reg[CTL_VBUS_DISCHARGE];
	assign dp_pullup_en = control_reg[CTL_LOCAL_CONNECT];
	assign dp_pulldown_en = control_reg[CTL_DP_PULLDOWN];
	assign dm_pulldown_en = control_reg[CTL_DM_PULLDOWN];

	// ---------------- line state and 2 ms SE0 ----------------
	wire se0_now = !pin_sync_reg[ST_DP] && !pin_sync_reg[ST_DM];
	logic [31:0] se0_count_reg;
	logic [31:0] se0_count_next;
	logic se0_long_reg;

	assign se0_count_next = !se0_now ? 32'h0000_0000 :
		(se0_long_reg ? se0_count_reg : se0_count_reg + 32'h0000_0001);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			se0_count_reg <= '0;
			se0_long_reg <= 1'b0;
		end else begin
			se0_count_reg <= se0_count_next;
			se0_long_reg <= se0_now && (se0_count_next >= 32'(SE0_TWO_MS_CYCLES));
		end
	end

	wire [ST_W-1:0] status_word = {se0_long_reg, se0_now, pin_sync_reg};

	// ---------------- session request detection ----------------
	// data-line pulsing: a rise on DP or DM while our own pull-up is off,
	// so the request cannot be confused with our own connect
	wire line_pulse = (pin_rise[ST_DP] || pin_rise[ST_DM]) &&
		!control_reg[CTL_LOCAL_CONNECT];
	// VBUS pulsing: session-valid rises while we are not sourcing VBUS
	wire vbus_pulse = pin_rise[ST_A_SESS_VLD] && !control_reg[CTL_VBUS_DRIVE];
	wire req_seen = control_reg[CTL_REQ_SELECT] ? line_pulse : vbus_pulse;
	wire session_req = control_reg[CTL_DETECT_EN] && req_seen;

	// ---------------- timer ----------------
	logic [TIMER_W-1:0] timer_count;
	logic timer_expired;

	negotiation_timer u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.load(wr_timer),
		.load_value(wr_data[TIMER_W-1:0]),
		.count(timer_count),
		.expired(timer_expired)
	);

	// ---------------- event flags and mask ----------------
	logic [EV_W-1:0] flags_reg;
	logic [EV_W-1:0] flags_next;
	logic [EV_W-1:0] mask_reg;
	logic [EV_W-1:0] mask_next;

	wire [EV_W-1:0] flag_set = {timer_expired, session_req,
		pin_change[ST_DP] || pin_change[ST_DM], pin_change[5:0]};
	wire [EV_W-1:0] flag_clear = wr_flags ? wr_data[EV_W-1:0] : '0;

	// a set in the same cycle as its clear wins, so no event is lost
	assign flags_next = (flags_reg & ~flag_clear) | flag_set;
	assign mask_next = wr_mask ? wr_data[EV_W-1:0] : mask_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_reg <= '0;
			mask_reg <= EV_MASK_RESET;
		end else begin
			flags_reg <= flags_next;
			mask_reg <= mask_next;
		end
	end

	wire [EV_W-1:0] flags_enabled = flags_reg & mask_reg;
	wire summary_event = |flags_enabled;

	// ---------------- host summary mask and config ----------------
	logic host_summary_mask_reg;
	logic [2:0] config_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			host_summary_mask_reg <= 1'b0;
			config_reg <= CFG_RESET;
		end else begin
			if (wr_host_mask) begin
				host_summary_mask_reg <= wr_data[HOST_SUMMARY];
			end
			if (wr_config) begin
				config_reg <= wr_data[2:0];
			end
		end
	end

	// ---------------- interrupt line ----------------
	wire irq_cond = summary_event && host_summary_mask_reg &&
		config_reg[CFG_PIN_GATE];
	logic irq_cond_prev_reg;
	logic [3:0] pulse_count_reg;
	logic [3:0] pulse_count_next;
	logic irq_out_reg;

	// edge mode emits a fixed pulse per new condition; a condition that stays
	// up through the service routine is not repeated, as with any edge input
	wire irq_rise = irq_cond && !irq_cond_prev_reg;
	assign pulse_count_next = irq_rise ? 4'(IRQ_PULSE_CYCLES) :
		(pulse_count_reg != 4'h0 ? pulse_count_reg - 4'h1 : 4'h0);
	wire irq_active_next = config_reg[CFG_EDGE_MODE] ?
		(pulse_count_next != 4'h0) : irq_cond;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_cond_prev_reg <= 1'b0;
			pulse_count_reg <= 4'h0;
			irq_out_reg <= 1'b1;
		end else begin
			irq_cond_prev_reg <= irq_cond;
			pulse_count_reg <= pulse_count_next;
			irq_out_reg <= irq_active_next ~^ config_reg[CFG_ACTIVE_HIGH];
		end
	end

	assign irq_line_one = irq_out_reg;

	// ---------------- power saving ----------------
	typedef enum logic {
		PWR_RUN,
		PWR_SLEEP
	} power_state_t;

	power_state_t power_reg;
	power_state_t power_next;

	wire in_session = pin_sync_reg[ST_B_SESS_VLD] || pin_sync_reg[ST_A_SESS_VLD] ||
		control_reg[CTL_VBUS_DRIVE];
	wire sleep_req = wr_power && wr_data[PWR_SAVE] && !in_session;
	wire access_wake = wr_strobe || rd_strobe;
	wire [EV_W-1:0] wake_events = flag_set & mask_reg &
		((EV_W'(1) << EV_SESSION_REQ) | (EV_W'(1) << ST_ID) |
		(EV_W'(1) << ST_B_SESS_VLD));
	// a B session-valid change is only a wake source when it is a rise
	wire event_wake = (|wake_events) &&
		(!flag_set[ST_B_SESS_VLD] || pin_sync_reg[ST_B_SESS_VLD] ||
		flag_set[EV_SESSION_REQ] || flag_set[ST_ID]);

	always_comb begin
		power_next = power_reg;
		unique case (power_reg)
			PWR_RUN: begin
				if (sleep_req) begin
					power_next = PWR_SLEEP;
				end
			end
			PWR_SLEEP: begin
				// the access that asked for sleep is itself not a wake
				if ((access_wake && !sleep_req) || event_wake) begin
					power_next = PWR_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			power_reg <= PWR_RUN;
			pll_osc_enable <= 1'b1;
			controllers_suspend <= 1'b0;
		end else begin
			power_reg <= power_next;
			pll_osc_enable <= power_next == PWR_RUN;
			controllers_suspend <= power_next == PWR_SLEEP;
		end
	end

	// ---------------- read path ----------------
	wire [DATA_W-1:0] host_flags_word = DATA_W'({summary_event, 9'h000});
	wire [DATA_W-1:0] power_word = DATA_W'({power_reg == PWR_RUN,
		power_reg == PWR_SLEEP});
	wire [DATA_W-1:0] rd_mux =
		sel_control ? DATA_W'(control_reg) :
		sel_status ? DATA_W'(status_word) :
		sel_flags ? DATA_W'(flags_reg) :
		sel_mask ? DATA_W'(mask_reg) :
		sel_timer ? DATA_W'(timer_count) :
		sel_host_flags ? host_flags_word :
		sel_host_mask ? DATA_W'({host_summary_mask_reg, 9'h000}) :
		sel_config ? DATA_W'(config_reg) :
		sel_power ? power_word :
		32'h0000_0000;
	logic [DATA_W-1:0] rd_data_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data_reg <= '0;
		end else begin
			rd_data_reg <= rd_strobe ? rd_mux : 32'h0000_0000;
		end
	end

	assign rd_data = rd_data_reg;
endmodule : dual_role_session

// >>> test/dual_role_session_properties.sv
`timescale 1ns/1ps
module dual_role_checker
	import dual_role_pkg::*;
#(
	parameter int SE0_TWO_MS_CYCLES = 50
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic [DATA_W-1:0] rd_data,
	// pad controls
	input wire logic vbus_drive,
	input wire logic vbus_charge,
	input wire logic vbus_discharge,
	input wire logic dp_pullup_en,
	input wire logic dp_pulldown_en,
	input wire logic dm_pulldown_en,
	// interrupt and power
	input wire logic irq_line_one,
	input wire logic pll_osc_enable,
	input wire logic controllers_suspend
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire ctl_wr = wr_strobe && addr == CONTROL_ADDR;
	wire [5:0] pads = {dm_pulldown_en, dp_pullup_en, dp_pulldown_en,
		vbus_discharge, vbus_charge, vbus_drive};
	chk_connect_pad: assert property (ctl_wr |=> dp_pullup_en == $past(wr_data[4]))
		else $error("pull-up does not follow control write");
	chk_charge_pad: assert property (ctl_wr |=> vbus_charge == $past(wr_data[1]))
		else $error("charge does not follow control write");
	chk_discharge_pad: assert property (ctl_wr |=> vbus_discharge == $past(wr_data[2]))
		else $error("discharge does not follow control write");
	chk_pad_hold: assert property (!ctl_wr |=> $stable(pads))
		else $error("pad controls moved without a control write");
	chk_read_quiet: assert property (!rd_strobe |=> rd_data == '0)
		else $error("read data outside its cycle");
	chk_unmapped_read: assert property (rd_strobe && addr == 8'hFC |=> rd_data == '0)
		else $error("unmapped read returned data");
	chk_sleep_pair: assert property (controllers_suspend == !pll_osc_enable)
		else $error("suspend and clock enable disagree");
	chk_access_wake: assert property (controllers_suspend && rd_strobe |=> pll_osc_enable)
		else $error("read access did not wake");
	chk_reset_irq: assert property ($rose(rst_n) |-> irq_line_one)
		else $error("interrupt line not idle high after reset");
	cover property (ctl_wr && wr_data[CTL_LOCAL_CONNECT]);
	cover property ($fell(irq_line_one));
	cover property ($rose(controllers_suspend));
endmodule : dual_role_checker

bind dual_role_session dual_role_checker #(.SE0_TWO_MS_CYCLES(SE0_TWO_MS_CYCLES)) chk (
	.clk, .rst_n, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .vbus_drive,
	.vbus_charge, .vbus_discharge, .dp_pullup_en, .dp_pulldown_en, .dm_pulldown_en,
	.irq_line_one, .pll_osc_enable, .controllers_suspend);

// >>> test/remote_port.sv
`timescale 1ns/1ps
module remote_port (
	// pad control from the block
	input wire logic dp_pullup_en,
	// sense pins
	output logic id_pin,
	output logic a_vbus_vld_pin,
	output logic b_sess_end_pin,
	output logic a_sess_vld_pin,
	output logic b_sess_vld_pin,
	output logic overcurrent_pin,
	output logic dp_pin,
	output logic dm_pin
);
	logic far_dp_reg;
	logic far_dm_reg;
	logic far_se0_reg;
	initial begin
		id_pin = 1'b1;
		a_vbus_vld_pin = 1'b0;
		b_sess_end_pin = 1'b1;
		a_sess_vld_pin = 1'b0;
		b_sess_vld_pin = 1'b0;
		overcurrent_pin = 1'b0;
		far_dp_reg = 1'b0;
		far_dm_reg = 1'b0;
		far_se0_reg = 1'b0;
	end
	// no keeper on the lines: with both pull-ups off the bus settles to se0;
	// a bus reset from the far host overrides every pull-up
	assign dp_pin = !far_se0_reg && (dp_pullup_en || far_dp_reg);
	assign dm_pin = !far_se0_reg && far_dm_reg;
	// pulse lengths are scaled down from milliseconds to keep the run short
	task pulse(input int src);
		#5;
		if (src == 0) far_dp_reg = 1'b1;
		else if (src == 1) far_dm_reg = 1'b1;
		else a_sess_vld_pin = 1'b1;
		#2000;
		far_dp_reg = 1'b0;
		far_dm_reg = 1'b0;
		a_sess_vld_pin = 1'b0;
	endtask : pulse
	task set_id(input logic v);
		#5;
		id_pin = v;
	endtask : set_id
	// far peripheral connects, or reconnects after handing the host role back
	task attach;
		#5;
		far_dp_reg = 1'b1;
	endtask : attach
	// far peripheral claims the host role after a long idle
	task claim_host;
		#5;
		far_dp_reg = 1'b0;
	endtask : claim_host
	// the settle time keeps a fading pull-up from passing for J
	task start_reset;
		#600;
		if (dp_pin && !dm_pin) far_se0_reg = 1'b1;
	endtask : start_reset
	task end_reset;
		#5;
		far_se0_reg = 1'b0;
	endtask : end_reset
endmodule : remote_port

// >>> test/dual_role_session_tb.sv
`timescale 1ns/1ps
module dual_role_session_tb;
	import dual_role_pkg::*;
	logic clk, rst_n, wr_strobe, rd_strobe;
	logic [7:0] addr;
	logic [31:0] wr_data, rd_data;
	logic id_pin, a_vbus_vld_pin, b_sess_end_pin, a_sess_vld_pin, b_sess_vld_pin;
	logic overcurrent_pin, dp_pin, dm_pin, vbus_drive, vbus_charge, vbus_discharge;
	logic dp_pullup_en, dp_pulldown_en, dm_pulldown_en, irq_line_one;
	logic pll_osc_enable, controllers_suspend;
	int error_cnt = 0;
	int n_compared = 0;
	dual_role_session #(.SE0_TWO_MS_CYCLES(50)) uut (.clk, .rst_n, .addr, .wr_data,
		.wr_strobe, .rd_strobe, .rd_data, .id_pin, .a_vbus_vld_pin, .b_sess_end_pin,
		.a_sess_vld_pin, .b_sess_vld_pin, .overcurrent_pin, .dp_pin, .dm_pin, .vbus_drive,
		.vbus_charge, .vbus_discharge, .dp_pullup_en, .dp_pulldown_en, .dm_pulldown_en,
		.irq_line_one, .pll_osc_enable, .controllers_suspend);
	remote_port far (.dp_pullup_en, .id_pin, .a_vbus_vld_pin, .b_sess_end_pin,
		.a_sess_vld_pin, .b_sess_vld_pin, .overcurrent_pin, .dp_pin, .dm_pin);
	initial clk = 1'b0;
	always #10 clk = ~clk;
	task stop_test;
		$display("Comparisons %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cyc
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
		#1;
	endtask : wr
	task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		check(rd_data & m, exp);
	endtask : rdm
	task test_reset;
		rdm(CONTROL_ADDR, '1, 0);
		rdm(EVENT_MASK_ADDR, '1, 0);
		rdm(HW_CONFIG_ADDR, '1, 0);
		check(irq_line_one, 1);
		check({controllers_suspend, pll_osc_enable}, 2'b01);
		rdm(8'hFC, '1, 0);
	endtask : test_reset
	task test_srp;
		wait_cyc(60);
		rdm(STATUS_ADDR, 32'h305, 32'h305);
		wr(CONTROL_ADDR, 32'h10);
		check(dp_pullup_en, 1);
		wait_cyc(10);
		rdm(STATUS_ADDR, 32'h340, 32'h040);
		wait_cyc(100);
		wr(CONTROL_ADDR, 32'h02);
		check({dp_pullup_en, vbus_charge}, 2'b01);
		wait_cyc(100);
		wr(CONTROL_ADDR, 32'h04);
		check({vbus_charge, vbus_discharge}, 2'b01);
		wr(CONTROL_ADDR, 32'hFFF);
		check({dm_pulldown_en, dp_pulldown_en, vbus_drive}, 3'b111);
		rdm(CONTROL_ADDR, '1, 32'h63F);
		wr(CONTROL_ADDR, 0);
	endtask : test_srp
	task test_detect;
		for (int i = 0; i < 6; i++) begin
			wr(CONTROL_ADDR, ((i < 3) ? 32'h400 : 32'h0) | (((i % 3) < 2) ? 32'h200 : 32'h0));
			wr(EVENT_FLAGS_ADDR, 32'h1FF);
			far.pulse(i % 3);
			wait_cyc(10);
			rdm(EVENT_FLAGS_ADDR, 32'h80, (i < 3) ? 32'h80 : 0);
			wr(EVENT_FLAGS_ADDR, 32'h80);
			rdm(EVENT_FLAGS_ADDR, 32'h80, 0);
		end
		wr(CONTROL_ADDR, 0);
	endtask : test_detect
	task test_timer;
		wr(EVENT_FLAGS_ADDR, 32'h1FF);
		wr(TIMER_ADDR, 3);
		wait_cyc(1400);
		rdm(EVENT_FLAGS_ADDR, 32'h100, 0);
		rdm(TIMER_ADDR, 32'hFFFF, 1);
		wait_cyc(150);
		rdm(EVENT_FLAGS_ADDR, 32'h100, 32'h100);
		wr(EVENT_FLAGS_ADDR, 32'h100);
		wait_cyc(600);
		rdm(EVENT_FLAGS_ADDR, 32'h100, 0);
	endtask : test_timer
	task test_irq;
		int n;
		n = 0;
		wr(EVENT_MASK_ADDR, 32'h100);
		wr(HOST_MASK_ADDR, 32'h200);
		wr(TIMER_ADDR, 1);
		wait_cyc(520);
		rdm(HOST_FLAGS_ADDR, 32'h200, 32'h200);
		check(irq_line_one, 1);
		wr(HW_CONFIG_ADDR, 1);
		wait_cyc(4);
		check(irq_line_one, 0);
		wr(HW_CONFIG_ADDR, 5);
		wait_cyc(4);
		check(irq_line_one, 1);
		wr(EVENT_MASK_ADDR, 0);
		wait_cyc(4);
		check(irq_line_one, 0);
		rdm(HOST_FLAGS_ADDR, 32'h200, 0);
		wr(EVENT_FLAGS_ADDR, 32'h1FF);
		wr(HW_CONFIG_ADDR, 3);
		wr(EVENT_MASK_ADDR, 32'h100);
		wr(TIMER_ADDR, 1);
		repeat (600) begin
			@(posedge clk);
			#1;
			if (irq_line_one === 1'b0) n++;
		end
		check(n, IRQ_PULSE_CYCLES);
		wr(HW_CONFIG_ADDR, 0);
		wr(EVENT_MASK_ADDR, 0);
	endtask : test_irq
	task test_power;
		wr(POWER_ADDR, 1);
		wait_cyc(2);
		check({controllers_suspend, pll_osc_enable}, 2'b10);
		rdm(POWER_ADDR, 32'h3, 32'h1);
		check({controllers_suspend, pll_osc_enable}, 2'b01);
		wr(POWER_ADDR, 1);
		far.set_id(0);
		wait_cyc(10);
		check(controllers_suspend, 1);
		wr(EVENT_MASK_ADDR, 1);
		check(controllers_suspend, 0);
		wr(POWER_ADDR, 1);
		far.set_id(1);
		wait_cyc(10);
		check({controllers_suspend, pll_osc_enable}, 2'b01);
	endtask : test_power
	// we act as the A-device; waits are scaled down like the request pulses
	task test_hnp;
		far.attach();
		wait_cyc(10);
		rdm(STATUS_ADDR, 32'h3C0, 32'h040);
		far.claim_host();
		wait_cyc(60);
		rdm(STATUS_ADDR, 32'h3C0, 32'h300);
		wr(CONTROL_ADDR, 32'h10);
		far.start_reset();
		wait_cyc(5);
		rdm(STATUS_ADDR, 32'h3C0, 32'h100);
		far.end_reset();
		wait_cyc(5);
		rdm(STATUS_ADDR, 32'h3C0, 32'h040);
		wait_cyc(20);
		wr(CONTROL_ADDR, 0);
		wait_cyc(5);
		rdm(STATUS_ADDR, 32'h3C0, 32'h100);
		far.attach();
		wait_cyc(30);
		rdm(STATUS_ADDR, 32'h3C0, 32'h040);
	endtask : test_hnp
	initial begin
		rst_n = 1'b0;
		addr = 0;
		wr_data = 0;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		test_reset();
		test_srp();
		test_detect();
		test_timer();
		test_irq();
		test_power();
		test_hnp();
		stop_test();
	end
	// runs take about 4600 cycles; the limit of 20000 cycles is over four times that
	initial begin
		#400000;
		error_cnt++;
		stop_test();
	end
endmodule : dual_role_session_tb
